// *** pkg/lane_clk_rst_pkg.sv ***
// Constants and carrier types for the lane link clock and reset controller.
// Assumes a single 50 MHz controller clock; all link clocks are made elsewhere.
package lane_clk_rst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 20_000;
  localparam int unsigned SETTLE_NS       = 10_000;
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ATTR_HOLD_NS    = 1_000;
  localparam int unsigned ATTR_HOLD_CYC   = (ATTR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CFG_CLK_MAX_HZ  = 250_000_000;
  localparam int unsigned CFG_CLK_HZ      = 25_000_000;
  localparam int unsigned CFG_HALF_CYC    = (CLK_HZ / (2 * CFG_CLK_HZ) < 1) ? 1 : CLK_HZ / (2 * CFG_CLK_HZ);
  localparam int unsigned CNT_W           = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Clock domains watched for stability
  localparam int unsigned NUM_DOM  = 4;
  localparam int unsigned DOM_CORE = 0;
  localparam int unsigned DOM_BUS  = 1;
  localparam int unsigned DOM_TXL  = 2;
  localparam int unsigned DOM_RXL  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic whole_core;
    logic tx_datapath;
    logic rx_datapath;
    logic tx_lane;
    logic rx_lane;
    logic tx_core;
    logic rx_core;
    logic tx_user_bus;
    logic rx_user_bus;
  } reset_bus_t;

  localparam reset_bus_t RST_ALL = 9'h1FF;

  typedef struct packed {
    logic rx_helper_from_tx;
    logic lane_clk_common;
  } clk_sel_t;

  // Frequencies in units of 0.1 Hz
  typedef struct packed {
    logic [31:0] rx_lane_dhz;
    logic [31:0] tx_lane_dhz;
    logic [31:0] core_dhz;
    logic [31:0] user_bus_dhz;
  } clk_plan_t;

  typedef enum logic [2:0] {
    RATE_25G78 = 3'h0,
    RATE_12G5  = 3'h1,
    RATE_10G31 = 3'h2,
    RATE_6G25  = 3'h3,
    RATE_5G    = 3'h4
  } rate_t;

  localparam logic [31:0] F_402M83 = 32'd4028320312;
  localparam logic [31:0] F_195M31 = 32'd1953120000;
  localparam logic [31:0] F_161M13 = 32'd1611328125;
  localparam logic [31:0] F_161M134 = 32'd1611340000;
  localparam logic [31:0] F_97M656 = 32'd976560000;
  localparam logic [31:0] F_78M125 = 32'd781250000;
  localparam logic [31:0] F_412M   = 32'd4120000000;
  localparam logic [31:0] F_300M   = 32'd3000000000;

  typedef enum logic [1:0] {
    ST_WHOLE    = 2'b00,
    ST_RUN      = 2'b01,
    ST_ATTR_HLD = 2'b10,
    ST_ATTR_ACK = 2'b11
  } state_t;

endpackage

// *** core/lane_clk_rst_ctrl.sv ***
// Host-side clock and reset controller for a multi-lane packet link core.
// Assumes clock-stable pins come from foreign domains and the rest from this clock.
//
// Operation
// (R01) Device clocks user-bus logic and rate adapter from user_bus_clk.
// (R02) Device control and status are mostly synchronous to user_bus_clk.
// (R03) Device runs protocol-layer logic on the core clock.
// (R04) Each device receive lane runs on its own recovered clock.
// (R05) With elastic buffer enabled, all lane clocks come from one common clock.
// (R06) Device transmit lanes all run from the single lane reference clock.
// (R07) Config port clock only during accesses, at most 250 MHz.
// (R08) One to six fast lanes: 402.8320312 MHz lanes, 412 core, 300 bus.
// (R09) Twelve lanes at 12.5G: 195.312 MHz lanes, 300 MHz core and bus.
// (R10) Device has separate receive and transmit resets, independent of each other.
// (R11) Device has a reset per clock domain within each path.
// (R12) Device needs no particular order of reset assertion or release.
// (R13) Hold each reset until its domain clock is fully stable.
// (R14) Whole-core reset resets transceivers and link block together.
// (R15) Datapath resets clear only their own direction.
// (R16) Hold user-bus reset while an in-reset attribute changes, until stable.
// (R17) Resets assert asynchronously and release synchronously.
// (R18) Synchronous mode: both helper blocks clock from transmit lane zero.
// (R19) Asynchronous mode: receive helper uses receive lane zero clock.
// (R20) Device transmitter encapsulates user packets; receiver strips it.
// (R21) Device user packet bus is 512 bits, segmented.
// (R22) Asserted means driven to 1, negated means driven to 0.
// (R23) Lane receive data sampled on rising edge of its recovered clock.
// (R24) Device synchronises each reset release inside its own domain.
`timescale 1ns/1ps

module lane_clk_rst_ctrl (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic [3:0]                    i_clk_stable,
  input  wire logic                          i_sync_mode,
  input  wire logic                          i_elastic_buf_en,
  input  wire lane_clk_rst_pkg::rate_t       i_rate_sel,
  input  wire logic                          i_attr_req,
  input  wire logic                          i_attr_rx,
  input  wire logic                          i_cfg_active,
  output      lane_clk_rst_pkg::reset_bus_t  o_resets,
  output      lane_clk_rst_pkg::clk_sel_t    o_clk_sel,
  output      lane_clk_rst_pkg::clk_plan_t   o_clk_plan,
  output      logic                          o_config_port_clk,
  output      logic                          o_attr_ack,
  output      logic                          o_ready
);
  import lane_clk_rst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Clock-stable pins cross in through two flops
  logic [NUM_DOM-1:0] stable_meta_q;
  logic [NUM_DOM-1:0] stable_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable_meta_q <= '0;
      stable_q      <= '0;
    end else begin
      stable_meta_q <= i_clk_stable;
      stable_q      <= stable_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-domain settle counters: a clock counts as stable only after a full quiet window
  logic [CNT_W-1:0]   dom_cnt_q [NUM_DOM];
  logic [CNT_W-1:0]   dom_cnt_d [NUM_DOM];
  logic [NUM_DOM-1:0] dom_ok;

  always_comb begin
    for (int i = 0; i < NUM_DOM; i++) begin
      if (!stable_q[i]) begin
        dom_cnt_d[i] = '0;
      end else if (dom_cnt_q[i] == CNT_W'(SETTLE_CYC)) begin
        dom_cnt_d[i] = dom_cnt_q[i];
      end else begin
        dom_cnt_d[i] = dom_cnt_q[i] + CNT_W'(1);
      end
      dom_ok[i] = (dom_cnt_q[i] == CNT_W'(SETTLE_CYC)); // R13
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NUM_DOM; i++) begin
        dom_cnt_q[i] <= '0;
      end
    end else begin
      dom_cnt_q <= dom_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  state_t           state_q;
  state_t           state_d;
  logic [CNT_W-1:0] attr_cnt_q;
  logic [CNT_W-1:0] attr_cnt_d;
  logic             attr_rx_q;
  logic             attr_rx_d;
  logic             sync_mode_q;
  logic             sync_mode_d;
  logic             elastic_q;
  logic             elastic_d;
  rate_t            rate_q;
  rate_t            rate_d;

  always_comb begin
    state_d     = state_q;
    attr_cnt_d  = attr_cnt_q;
    attr_rx_d   = attr_rx_q;
    sync_mode_d = sync_mode_q;
    elastic_d   = elastic_q;
    rate_d      = rate_q;
    unique case (state_q)
      ST_WHOLE: begin
        // Clock plan and mode are only taken while everything is held
        sync_mode_d = i_sync_mode;
        elastic_d   = i_elastic_buf_en;
        rate_d      = i_rate_sel;
        if (&dom_ok) begin
          state_d = ST_RUN; // R13
        end
      end
      ST_RUN: begin
        if (i_attr_req) begin
          state_d    = ST_ATTR_HLD; // R16
          attr_rx_d  = i_attr_rx;
          attr_cnt_d = '0;
        end
      end
      ST_ATTR_HLD: begin
        attr_cnt_d = attr_cnt_q + CNT_W'(1);
        if (attr_cnt_q == CNT_W'(ATTR_HOLD_CYC - 1)) begin
          state_d = ST_ATTR_ACK;
        end
      end
      ST_ATTR_ACK: begin
        // Reset stays on until the requester says the new value has settled
        if (!i_attr_req) begin
          state_d = ST_RUN; // R16
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= ST_WHOLE;
      attr_cnt_q  <= '0;
      attr_rx_q   <= 1'b0;
      sync_mode_q <= 1'b1;
      elastic_q   <= 1'b0;
      rate_q      <= RATE_12G5;
    end else begin
      state_q     <= state_d;
      attr_cnt_q  <= attr_cnt_d;
      attr_rx_q   <= attr_rx_d;
      sync_mode_q <= sync_mode_d;
      elastic_q   <= elastic_d;
      rate_q      <= rate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs; a lost clock raises only the resets of the domains it feeds
  reset_bus_t rst_q;
  reset_bus_t rst_d;
  logic       attr_hold;
  logic       whole;
  logic       ack_q;
  logic       ack_d;
  logic       ready_q;
  logic       ready_d;

  always_comb begin
    whole             = (state_q == ST_WHOLE);
    attr_hold         = (state_q == ST_ATTR_HLD) || (state_q == ST_ATTR_ACK);
    rst_d.whole_core  = whole; // R14
    rst_d.rx_datapath = whole | ~dom_ok[DOM_RXL]; // R15
    rst_d.tx_datapath = whole | ~dom_ok[DOM_TXL]; // R15
    rst_d.rx_lane     = whole | ~dom_ok[DOM_RXL]; // R13 R23
    rst_d.tx_lane     = whole | ~dom_ok[DOM_TXL]; // R13
    rst_d.rx_core     = whole | ~dom_ok[DOM_CORE]; // R13
    rst_d.tx_core     = whole | ~dom_ok[DOM_CORE]; // R13
    rst_d.rx_user_bus = whole | ~dom_ok[DOM_BUS] | (attr_hold & attr_rx_q); // R16
    rst_d.tx_user_bus = whole | ~dom_ok[DOM_BUS] | (attr_hold & ~attr_rx_q); // R16
    ack_d             = (state_d == ST_ATTR_ACK);
    ready_d           = ~|rst_d;
  end

  // Power-on reset forces every output reset high at once; release is on this clock edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q   <= RST_ALL; // R17
      ack_q   <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rst_q   <= rst_d; // R17
      ack_q   <= ack_d;
      ready_q <= ready_d;
    end
  end

  assign o_resets   = rst_q; // R22
  assign o_attr_ack = ack_q;
  assign o_ready    = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection and frequency plan
  clk_sel_t  sel_q;
  clk_sel_t  sel_d;
  clk_plan_t plan_q;
  clk_plan_t plan_d;

  always_comb begin
    sel_d.rx_helper_from_tx = sync_mode_q; // R18 R19
    sel_d.lane_clk_common   = elastic_q; // R05
    plan_d.core_dhz         = F_300M;
    plan_d.user_bus_dhz     = F_300M;
    plan_d.rx_lane_dhz      = F_195M31;
    plan_d.tx_lane_dhz      = F_195M31;
    unique case (rate_q)
      RATE_25G78: begin
        plan_d.rx_lane_dhz = F_402M83; // R08
        plan_d.tx_lane_dhz = F_402M83;
        plan_d.core_dhz    = F_412M;
      end
      RATE_12G5: begin
        plan_d.rx_lane_dhz = F_195M31; // R09
        plan_d.tx_lane_dhz = F_195M31;
      end
      RATE_10G31: begin
        plan_d.rx_lane_dhz = F_161M13; // R09
        plan_d.tx_lane_dhz = F_161M134;
      end
      RATE_6G25: begin
        plan_d.rx_lane_dhz = F_97M656; // R09
        plan_d.tx_lane_dhz = F_97M656;
      end
      RATE_5G: begin
        plan_d.rx_lane_dhz = F_78M125; // R09
        plan_d.tx_lane_dhz = F_78M125;
      end
      default: begin
        plan_d.rx_lane_dhz = F_195M31;
        plan_d.tx_lane_dhz = F_195M31;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q  <= '0;
      plan_q <= '0;
    end else begin
      sel_q  <= sel_d;
      plan_q <= plan_d;
    end
  end

  assign o_clk_sel  = sel_q;
  assign o_clk_plan = plan_q;

  ////////////////////////////////////////////////////////////////////////////
  // Config port clock: runs only during accesses, well under its ceiling
  logic [CNT_W-1:0] cfg_cnt_q;
  logic [CNT_W-1:0] cfg_cnt_d;
  logic             cfg_clk_q;
  logic             cfg_clk_d;
  logic             cfg_tick;

  always_comb begin
    cfg_tick  = (cfg_cnt_q == CNT_W'(CFG_HALF_CYC - 1));
    cfg_cnt_d = cfg_tick ? '0 : cfg_cnt_q + CNT_W'(1);
    cfg_clk_d = cfg_tick ? ~cfg_clk_q : cfg_clk_q;
    if (!i_cfg_active) begin
      // Parks low so a stopped clock never leaves a short high pulse
      cfg_cnt_d = '0;
      cfg_clk_d = 1'b0; // R07
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_cnt_q <= '0;
      cfg_clk_q <= 1'b0;
    end else begin
      cfg_cnt_q <= cfg_cnt_d;
      cfg_clk_q <= cfg_clk_d;
    end
  end

  assign o_config_port_clk = cfg_clk_q;

endmodule

// *** dv/lane_clk_rst_ctrl_props.sv ***
// Port-level assertions for the lane clock and reset controller.
// Assumes one controller clock; bound to every instance below.
`timescale 1ns/1ps
module lane_clk_rst_ctrl_props (
  input wire logic                         i_clk,
  input wire logic                         i_rst_n,
  input wire logic [3:0]                   i_clk_stable,
  input wire logic                         i_sync_mode,
  input wire logic                         i_elastic_buf_en,
  input wire lane_clk_rst_pkg::rate_t      i_rate_sel,
  input wire logic                         i_attr_req,
  input wire logic                         i_attr_rx,
  input wire logic                         i_cfg_active,
  input wire lane_clk_rst_pkg::reset_bus_t o_resets,
  input wire lane_clk_rst_pkg::clk_sel_t   o_clk_sel,
  input wire lane_clk_rst_pkg::clk_plan_t  o_clk_plan,
  input wire logic                         o_config_port_clk,
  input wire logic                         o_attr_ack,
  input wire logic                         o_ready
);
  import lane_clk_rst_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence attr_taken;
    o_ready && i_attr_req && i_attr_rx;
  endsequence
  sequence bus_rst_rise;
    $rose(o_resets.rx_user_bus || o_resets.tx_user_bus) && i_attr_req;
  endsequence
  chk_ready_clear: assert property (o_ready == (o_resets == 9'h000))
    else $error("ready with a reset high");
  chk_cfg_toggle: assert property (i_cfg_active && $past(i_cfg_active) |=> $changed(o_config_port_clk))
    else $error("config clock stalled");
  chk_whole_once: assert property (!o_resets.whole_core |=> !o_resets.whole_core)
    else $error("whole reset reasserted");
  chk_mode_frozen: assert property (!o_resets.whole_core |=> $stable(o_clk_sel) && $stable(o_clk_plan))
    else $error("clock plan moved");
  chk_attr_hold: assert property (attr_taken |-> ##3 o_resets.rx_user_bus)
    else $error("bus reset not held");
  chk_ack_time: assert property (bus_rst_rise |-> ##49 o_attr_ack)
    else $error("ack late");
  chk_ack_exact: assert property ($rose(o_attr_ack) |-> $past(o_ready, 50) && !$past(o_ready, 49))
    else $error("ack early");
  chk_core_loss: assert property ($fell(i_clk_stable[0]) |-> ##[3:5] o_resets.rx_core && o_resets.tx_core)
    else $error("core reset missing");
endmodule

bind lane_clk_rst_ctrl lane_clk_rst_ctrl_props u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clk_stable(i_clk_stable), .i_sync_mode(i_sync_mode),
  .i_elastic_buf_en(i_elastic_buf_en), .i_rate_sel(i_rate_sel), .i_attr_req(i_attr_req),
  .i_attr_rx(i_attr_rx), .i_cfg_active(i_cfg_active), .o_resets(o_resets), .o_clk_sel(o_clk_sel),
  .o_clk_plan(o_clk_plan), .o_config_port_clk(o_config_port_clk), .o_attr_ack(o_attr_ack), .o_ready(o_ready)
);

// *** dv/link_core_model.sv ***
// Behavioural link core with its clock sources.
// One bench clock stands in for every domain; losses are commanded.
`timescale 1ns/1ps
module link_core_model (
  input  wire logic                         i_clk,
  input  wire lane_clk_rst_pkg::reset_bus_t i_resets,
  input  wire logic [3:0]                   i_lose,
  output      logic [3:0]                   o_clk_stable,
  output      logic [3:0]                   o_up
);
  import lane_clk_rst_pkg::*;
  logic [3:0] hit;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  assign hit[0] = i_resets.whole_core | i_resets.rx_core | i_resets.tx_core;
  assign hit[1] = i_resets.whole_core | i_resets.rx_user_bus | i_resets.tx_user_bus;
  assign hit[2] = i_resets.whole_core | i_resets.tx_datapath | i_resets.tx_lane;
  assign hit[3] = i_resets.whole_core | i_resets.rx_datapath | i_resets.rx_lane;
  assign o_clk_stable = ~i_lose;
  assign o_up = s2_q;
  // Assert at once, release two edges later so no domain leaves reset mid-cycle
  for (genvar d = 0; d < 4; d++) begin : g_sync
    always_ff @(posedge i_clk or posedge hit[d]) begin
      if (hit[d]) begin
        s1_q[d] <= 1'b0;
        s2_q[d] <= 1'b0;
      end else begin
        s1_q[d] <= 1'b1;
        s2_q[d] <= s1_q[d];
      end
    end
  end
endmodule

// *** dv/lane_clk_rst_ctrl_tb.sv ***
// Self-checking bench for the lane clock and reset controller.
// Inputs move 1 ns after each rising edge; the core model reports clocks.
`timescale 1ns/1ps
module lane_clk_rst_ctrl_tb;
  import lane_clk_rst_pkg::*;
  logic       i_clk = 1'b0, i_rst_n = 1'b0, i_sync_mode = 1'b0, i_elastic_buf_en = 1'b0;
  logic       i_attr_req = 1'b0, i_attr_rx = 1'b0, i_cfg_active = 1'b0, c;
  logic       o_config_port_clk, o_attr_ack, o_ready;
  logic [3:0] lose = 4'hF, i_clk_stable, up;
  rate_t      i_rate_sel = RATE_25G78;
  reset_bus_t o_resets, exp_rst;
  clk_sel_t   o_clk_sel;
  clk_plan_t  o_clk_plan;
  logic [31:0] seed = 32'h53363EBB;
  int         num_errors = 0, check_count = 0;

  always #10 i_clk = ~i_clk;

  lane_clk_rst_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_clk_stable(i_clk_stable),
    .i_sync_mode(i_sync_mode), .i_elastic_buf_en(i_elastic_buf_en), .i_rate_sel(i_rate_sel),
    .i_attr_req(i_attr_req), .i_attr_rx(i_attr_rx), .i_cfg_active(i_cfg_active), .o_resets(o_resets),
    .o_clk_sel(o_clk_sel), .o_clk_plan(o_clk_plan), .o_config_port_clk(o_config_port_clk),
    .o_attr_ack(o_attr_ack), .o_ready(o_ready));
  link_core_model u_core (.i_clk(i_clk), .i_resets(o_resets), .i_lose(lose), .o_clk_stable(i_clk_stable),
    .o_up(up));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic clk_plan_t plan_of(input rate_t r);
    case (r)
      RATE_25G78: return {F_402M83, F_402M83, F_412M, F_300M};
      RATE_12G5: return {F_195M31, F_195M31, F_300M, F_300M};
      RATE_10G31: return {F_161M13, F_161M134, F_300M, F_300M};
      RATE_6G25: return {F_97M656, F_97M656, F_300M, F_300M};
      default: return {F_78M125, F_78M125, F_300M, F_300M};
    endcase
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait on ready or ack; a hang ends the run
  task automatic wait_for(input logic ack);
    int k;
    for (k = 0; k < 800 && (ack ? o_attr_ack : o_ready) !== 1'b1; k++) step(1);
    if (k == 800) begin
      check(k, 0);
      give_verdict();
    end
  endtask

  initial begin
    for (int r = 0; r < 5; r++) begin
      i_rst_n = 1'b0;
      lose = 4'hF;
      step(12);
      check(o_resets, RST_ALL);
      check(o_clk_sel, 0);
      check(o_clk_plan, 0);
      check(o_ready, 0);
      seed = lfsr(seed);
      // First four runs walk every mode pair by hand, the last one is drawn
      {i_sync_mode, i_elastic_buf_en} = (r < 4) ? 2'(r) : seed[1:0];
      i_rate_sel = rate_t'(r);
      i_rst_n = 1'b1;
      lose = seed[5:2];
      step(seed[10:6]);
      lose = 4'h0;
      step(400);
      check(o_ready, 0);
      wait_for(0);
      i_sync_mode = ~i_sync_mode;
      step(3);
      check(o_resets, 0);
      check(o_clk_sel, {~i_sync_mode, i_elastic_buf_en});
      check(o_clk_plan, plan_of(rate_t'(r)));
      check(up, 4'hF);
      $display("mode test %0d done", r);
    end
    for (int d = 0; d < 4; d++) begin
      lose = 4'h1 << d;
      step(6);
      exp_rst = (d == 0) ? 9'h00C : (d == 1) ? 9'h003 : (d == 2) ? 9'h0A0 : 9'h050;
      check(o_resets, exp_rst);
      check(up, 4'hF ^ (4'h1 << d));
      lose = 4'h0;
      wait_for(0);
    end
    $display("clock loss test done");
    // Back-to-back requests, each raised right after the last one's resets and ack read clear
    for (int n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      // First two requests force one of each path, the rest are drawn
      i_attr_rx = (n < 2) ? n[0] : seed[0];
      i_attr_req = 1'b1;
      exp_rst = i_attr_rx ? 9'h001 : 9'h002;
      step(3);
      check(o_resets, exp_rst);
      i_attr_rx = ~i_attr_rx;
      wait_for(1);
      check(o_resets, exp_rst);
      step(seed[5:1]);
      i_attr_req = 1'b0;
      step(3);
      check({o_resets, o_attr_ack}, 0);
    end
    $display("attribute test done");
    i_cfg_active = 1'b1;
    step(2);
    c = o_config_port_clk;
    repeat (8) begin
      step(1);
      check(o_config_port_clk, {~c});
      c = o_config_port_clk;
    end
    i_cfg_active = 1'b0;
    step(2);
    check(o_config_port_clk, 0);
    $display("config clock test done");
    give_verdict();
  end
endmodule
